// ==== core/nvm_port_pkg.sv ====
// Notes on behaviour
// - action lines pick address, data, command, idle
// - ready low while busy, high when ready
// - page latch stores data word in buffer
// - action 00, select 10 loads address top byte
// - flash write strobe programs whole buffered page
// - writes hold busy 3.7 to 4.5 ms
// - chip erase busy 12 to 14.5 ms
// - busy starts within 1 us of strobe
// - zero command is no-op, clears write state
// - eeprom command loads page by latch pulses
// - eeprom write strobe programs buffered page
// - flash read drives low or high byte
// - eeprom read drives addressed byte
// - fuse write: zero programs, one erases
// - byte select picks low, high, extended fuse
// - lock write programs bits that are zero
// - mode 3 locks refuse boot lock programming
// - only chip erase clears lock bits
// - byte select picks fuse or lock readback
// - signature byte by low address 0 to 2
// - calibration byte with select one high
package nvm_port_pkg;

    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NOP        = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
    localparam logic [7:0] CMD_RD_SIG     = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;
    localparam logic [1:0] SEL_LO   = 2'h0;
    localparam logic [1:0] SEL_HI   = 2'h1;
    localparam logic [1:0] SEL_EXT  = 2'h2;
    localparam logic [1:0] SEL_RSV  = 2'h3;

    // ------------------------------------------------------------
    // storage sizes (flip-flop model, small on purpose)
    // ------------------------------------------------------------
    localparam int PAGE_WORDS  = 8;
    localparam int PAGE_AW     = 3;
    localparam int FLASH_WORDS = 64;
    localparam int FLASH_AW    = 6;
    localparam int EE_BYTES    = 64;
    localparam int EE_AW       = 6;
    localparam logic [7:0] ERASED      = 8'hff;
    localparam logic [7:0] FUSE_LO_RST = 8'hff;
    localparam logic [7:0] FUSE_HI_RST = 8'hff;
    localparam logic [7:0] FUSE_EX_RST = 8'hff;
    localparam logic [7:0] LOCK_RST    = 8'hff;
    localparam logic [7:0] LOCK_MODE   = 8'h03;   // lock_bit_one, lock_bit_two
    localparam logic [7:0] BOOT_LOCKS  = 8'h3c;
    localparam logic [7:0] SIG_LAST    = 8'h02;
    localparam logic [7:0] CAL_ADDR    = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 40_000_000;
    localparam int WR_TIME_US   = 4000;    // inside 3.7 .. 4.5 ms
    localparam int CE_TIME_US   = 13000;   // inside 12 .. 14.5 ms
    localparam int WR_CYCLES    = WR_TIME_US * (CLK_HZ / 1_000_000);
    localparam int CE_CYCLES    = CE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int TIMER_W      = 20;

    typedef struct packed {
        logic [1:0] act;
        logic [1:0] sel;
        logic [7:0] data;
    } ctrl_s;

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} state_e;

endpackage

// ==== core/nvm_edge_sync.sv ====
`timescale 1ns/100ps
module nvm_edge_sync
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic [2:0] sh_r;

    // two stages before any logic reads the pin
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sh_r <= 3'h0;
        else
            sh_r <= {sh_r[1:0], pin};
    end

    assign rise = sh_r[1] & ~sh_r[2];
    assign fall = ~sh_r[1] & sh_r[2];
endmodule

// ==== core/nvm_prog_port.sv ====
`timescale 1ns/100ps
module nvm_prog_port
#(
    parameter int WR_CYC = nvm_port_pkg::WR_CYCLES,
    parameter int CE_CYC = nvm_port_pkg::CE_CYCLES,
    parameter logic [7:0] SIG0 = 8'h11,  // arbitrary identity value
    parameter logic [7:0] SIG1 = 8'h22,  // arbitrary identity value
    parameter logic [7:0] SIG2 = 8'h33,  // arbitrary identity value
    parameter logic [7:0] CAL  = 8'h80
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       action_select_hi,
    input  wire logic       action_select_lo,
    input  wire logic       byte_select_one,
    input  wire logic       byte_select_two,
    input  wire logic       load_clock,
    input  wire logic       page_latch_strobe,
    input  wire logic       write_n,
    input  wire logic       output_enable_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            ready_busy_flag
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    nvm_port_pkg::ctrl_s ctl_m_r;
    nvm_port_pkg::ctrl_s ctl_r;
    logic [1:0]          oe_sh_r;
    logic                clk_rise;
    logic                pgl_rise;
    logic                wr_fall;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_m_r <= '0;
            ctl_r   <= '0;
            oe_sh_r <= 2'h3;
        end
        else
        begin
            ctl_m_r <= {action_select_hi, action_select_lo,
                        byte_select_two, byte_select_one, data_in};
            ctl_r   <= ctl_m_r;
            oe_sh_r <= {oe_sh_r[0], output_enable_n};
        end
    end

    nvm_edge_sync u_clk (.clk(clk), .rst_n(rst_n), .pin(load_clock),
                         .rise(clk_rise), .fall());
    nvm_edge_sync u_pgl (.clk(clk), .rst_n(rst_n), .pin(page_latch_strobe),
                         .rise(pgl_rise), .fall());
    nvm_edge_sync u_wr  (.clk(clk), .rst_n(rst_n), .pin(write_n),
                         .rise(), .fall(wr_fall));

    // ------------------------------------------------------------
    // command, address and data latches
    // ------------------------------------------------------------
    logic [7:0] cmd_r;
    logic [7:0] addr_lo_r;
    logic [7:0] addr_hi_r;
    logic [7:0] addr_ex_r;
    logic [7:0] dat_lo_r;
    logic [7:0] dat_hi_r;
    logic       wr_armed_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_r      <= nvm_port_pkg::CMD_NOP;
            addr_lo_r  <= 8'h00;
            addr_hi_r  <= 8'h00;
            addr_ex_r  <= 8'h00;
            dat_lo_r   <= 8'h00;
            dat_hi_r   <= 8'h00;
            wr_armed_r <= 1'b0;
        end
        else if (clk_rise)
        begin
            unique case (ctl_r.act)
                nvm_port_pkg::ACT_ADDR:
                begin
                    if (ctl_r.sel == nvm_port_pkg::SEL_LO)
                        addr_lo_r <= ctl_r.data;
                    else if (ctl_r.sel == nvm_port_pkg::SEL_HI)
                        addr_hi_r <= ctl_r.data;
                    else if (ctl_r.sel == nvm_port_pkg::SEL_EXT)
                        addr_ex_r <= ctl_r.data;
                end
                nvm_port_pkg::ACT_DATA:
                begin
                    if (ctl_r.sel[0])
                        dat_hi_r <= ctl_r.data;
                    else
                        dat_lo_r <= ctl_r.data;
                end
                nvm_port_pkg::ACT_CMD:
                begin
                    cmd_r      <= ctl_r.data;
                    // zero command drops the write control
                    wr_armed_r <= (ctl_r.data != nvm_port_pkg::CMD_NOP);
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // page buffer and arrays
    // ------------------------------------------------------------
    logic [15:0] pbuf_r  [nvm_port_pkg::PAGE_WORDS];
    logic [15:0] flash_r [nvm_port_pkg::FLASH_WORDS];
    logic [7:0]  ee_r    [nvm_port_pkg::EE_BYTES];
    logic [7:0]  fuse_lo_r;
    logic [7:0]  fuse_hi_r;
    logic [7:0]  fuse_ex_r;
    logic [7:0]  lock_r;
    logic [nvm_port_pkg::PAGE_AW-1:0]  pidx;
    logic [nvm_port_pkg::FLASH_AW-1:0] fidx;
    logic [nvm_port_pkg::EE_AW-1:0]    eidx;

    assign pidx = addr_lo_r[nvm_port_pkg::PAGE_AW-1:0];
    assign fidx = addr_lo_r[nvm_port_pkg::FLASH_AW-1:0];
    assign eidx = addr_lo_r[nvm_port_pkg::EE_AW-1:0];

    // page base of an address: the word bits cleared
    function automatic logic [nvm_port_pkg::FLASH_AW-1:0] page_base(
        input logic [nvm_port_pkg::FLASH_AW-1:0] a);
        page_base = {a[nvm_port_pkg::FLASH_AW-1:nvm_port_pkg::PAGE_AW],
                     {nvm_port_pkg::PAGE_AW{1'b0}}};
    endfunction

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    nvm_port_pkg::state_e               state_r;
    logic [nvm_port_pkg::TIMER_W-1:0]   timer_r;
    logic [7:0]                         op_cmd_r;
    logic [1:0]                         op_sel_r;
    logic                               start;
    logic                               is_write;

    assign is_write = (cmd_r == nvm_port_pkg::CMD_CHIP_ERASE)
                   || (cmd_r == nvm_port_pkg::CMD_WR_FUSE)
                   || (cmd_r == nvm_port_pkg::CMD_WR_LOCK)
                   || (cmd_r == nvm_port_pkg::CMD_WR_FLASH)
                   || (cmd_r == nvm_port_pkg::CMD_WR_EEPROM);
    // strobes during a busy period are ignored
    assign start = wr_fall && wr_armed_r && is_write
                && (state_r == nvm_port_pkg::ST_IDLE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r         <= nvm_port_pkg::ST_IDLE;
            timer_r         <= '0;
            op_cmd_r        <= nvm_port_pkg::CMD_NOP;
            op_sel_r        <= nvm_port_pkg::SEL_LO;
            ready_busy_flag <= 1'b1;
        end
        else
        begin
            unique case (state_r)
                nvm_port_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        state_r         <= nvm_port_pkg::ST_BUSY;
                        op_cmd_r        <= cmd_r;
                        op_sel_r        <= ctl_r.sel;
                        ready_busy_flag <= 1'b0;
                        if (cmd_r == nvm_port_pkg::CMD_CHIP_ERASE)
                            timer_r <= nvm_port_pkg::TIMER_W'(CE_CYC - 1);
                        else
                            timer_r <= nvm_port_pkg::TIMER_W'(WR_CYC - 1);
                    end
                end
                nvm_port_pkg::ST_BUSY:
                begin
                    if (timer_r == '0)
                    begin
                        state_r         <= nvm_port_pkg::ST_IDLE;
                        ready_busy_flag <= 1'b1;
                    end
                    else
                        timer_r <= timer_r - 1'b1;
                end
            endcase
        end
    end

    logic done;
    assign done = (state_r == nvm_port_pkg::ST_BUSY) && (timer_r == '0);

    // page buffer fill and clear after commit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < nvm_port_pkg::PAGE_WORDS; i++)
                pbuf_r[i] <= {nvm_port_pkg::ERASED, nvm_port_pkg::ERASED};
        end
        else if (done && (op_cmd_r == nvm_port_pkg::CMD_WR_FLASH
                       || op_cmd_r == nvm_port_pkg::CMD_WR_EEPROM))
        begin
            for (int i = 0; i < nvm_port_pkg::PAGE_WORDS; i++)
                pbuf_r[i] <= {nvm_port_pkg::ERASED, nvm_port_pkg::ERASED};
        end
        else if (pgl_rise)
            pbuf_r[pidx] <= {dat_hi_r, dat_lo_r};
    end

    // arrays commit at the end of the busy period
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < nvm_port_pkg::FLASH_WORDS; i++)
                flash_r[i] <= {nvm_port_pkg::ERASED, nvm_port_pkg::ERASED};
            for (int i = 0; i < nvm_port_pkg::EE_BYTES; i++)
                ee_r[i] <= nvm_port_pkg::ERASED;
        end
        else if (done)
        begin
            if (op_cmd_r == nvm_port_pkg::CMD_CHIP_ERASE)
            begin
                for (int i = 0; i < nvm_port_pkg::FLASH_WORDS; i++)
                    flash_r[i] <= {nvm_port_pkg::ERASED, nvm_port_pkg::ERASED};
                for (int i = 0; i < nvm_port_pkg::EE_BYTES; i++)
                    ee_r[i] <= nvm_port_pkg::ERASED;
            end
            else if (op_cmd_r == nvm_port_pkg::CMD_WR_FLASH)
            begin
                for (int i = 0; i < nvm_port_pkg::PAGE_WORDS; i++)
                    flash_r[page_base(fidx) + i[nvm_port_pkg::FLASH_AW-1:0]]
                        <= pbuf_r[i];
            end
            else if (op_cmd_r == nvm_port_pkg::CMD_WR_EEPROM)
            begin
                for (int i = 0; i < nvm_port_pkg::PAGE_WORDS; i++)
                    ee_r[page_base(eidx) + i[nvm_port_pkg::EE_AW-1:0]]
                        <= pbuf_r[i][7:0];
            end
        end
    end

    // fuses and locks; locks only clear through chip erase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fuse_lo_r <= nvm_port_pkg::FUSE_LO_RST;
            fuse_hi_r <= nvm_port_pkg::FUSE_HI_RST;
            fuse_ex_r <= nvm_port_pkg::FUSE_EX_RST;
            lock_r    <= nvm_port_pkg::LOCK_RST;
        end
        else if (done)
        begin
            if (op_cmd_r == nvm_port_pkg::CMD_CHIP_ERASE)
                lock_r <= nvm_port_pkg::LOCK_RST;
            else if (op_cmd_r == nvm_port_pkg::CMD_WR_LOCK)
            begin
                if ((lock_r & nvm_port_pkg::LOCK_MODE) == 8'h00)
                    lock_r <= lock_r & (dat_lo_r | nvm_port_pkg::BOOT_LOCKS);
                else
                    lock_r <= lock_r & dat_lo_r;
            end
            else if (op_cmd_r == nvm_port_pkg::CMD_WR_FUSE)
            begin
                if (op_sel_r == nvm_port_pkg::SEL_HI)
                    fuse_hi_r <= dat_lo_r;
                else if (op_sel_r == nvm_port_pkg::SEL_EXT)
                    fuse_ex_r <= dat_lo_r;
                else if (op_sel_r == nvm_port_pkg::SEL_LO)
                    fuse_lo_r <= dat_lo_r;
            end
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    logic [7:0] rd_val;
    logic       rd_ok;

    always_comb
    begin
        rd_val = 8'h00;
        rd_ok  = 1'b1;
        unique case (cmd_r)
            nvm_port_pkg::CMD_RD_FLASH:
                rd_val = ctl_r.sel[0] ? flash_r[fidx][15:8] : flash_r[fidx][7:0];
            nvm_port_pkg::CMD_RD_EEPROM:
                rd_val = ee_r[eidx];
            nvm_port_pkg::CMD_RD_FUSE:
            begin
                unique case (ctl_r.sel)
                    nvm_port_pkg::SEL_LO:  rd_val = fuse_lo_r;
                    nvm_port_pkg::SEL_RSV: rd_val = fuse_hi_r;
                    nvm_port_pkg::SEL_EXT: rd_val = fuse_ex_r;
                    nvm_port_pkg::SEL_HI:  rd_val = lock_r;
                endcase
            end
            nvm_port_pkg::CMD_RD_SIG:
            begin
                if (ctl_r.sel[0])
                begin
                    rd_ok  = (addr_lo_r == nvm_port_pkg::CAL_ADDR);
                    rd_val = CAL;
                end
                else if (addr_lo_r <= nvm_port_pkg::SIG_LAST)
                    rd_val = (addr_lo_r == 8'h00) ? SIG0 :
                             (addr_lo_r == 8'h01) ? SIG1 : SIG2;
                else
                    rd_ok = 1'b0;
            end
            default:
                rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_out <= rd_val;
            data_oe  <= ~oe_sh_r[1] && rd_ok;
        end
    end
endmodule

// ==== testbench/nvm_prog_port_sva.sv ====
`timescale 1ns/100ps
module nvm_prog_port_sva
#(
    parameter int WR_CYC = 20,
    parameter int CE_CYC = 60
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic data_oe,
    input wire logic ready_busy_flag
);
    localparam int CE_MAX = CE_CYC + 8;
    logic        wr_q;
    logic [7:0]  since_wr;
    logic [19:0] busy_len;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // saturates: a stray busy start still fails
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q     <= 1'b1;
            since_wr <= 8'hff;
            busy_len <= '0;
        end
        else
        begin
            wr_q <= write_n;
            busy_len <= ready_busy_flag ? 20'h0 : busy_len + 20'h1;
            if (wr_q && !write_n)
                since_wr <= 8'h00;
            else if (since_wr != 8'hff)
                since_wr <= since_wr + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_BUSY_START: assert property ($fell(ready_busy_flag) |-> since_wr < 8'd40)
        else $error("busy without strobe");
    AST_BUSY_WR: assert property ($rose(ready_busy_flag) && busy_len < CE_CYC / 2
        |-> busy_len + 8 >= WR_CYC && busy_len <= WR_CYC + 8)
        else $error("write busy length");
    AST_BUSY_CE: assert property ($rose(ready_busy_flag) && busy_len >= CE_CYC / 2
        |-> busy_len + 8 >= CE_CYC && busy_len <= CE_CYC + 8)
        else $error("erase busy length");
    AST_BUSY_BOUND: assert property ($fell(ready_busy_flag) |-> ##[1:CE_MAX] ready_busy_flag)
        else $error("busy never ended");
    AST_READY_HOLD: assert property ($rose(ready_busy_flag) |-> ready_busy_flag [*4])
        else $error("busy retriggered");
    AST_OE_RELEASE: assert property (output_enable_n [*5] |-> !data_oe)
        else $error("drive while disabled");
    AST_OE_CAUSE: assert property ($rose(data_oe) |-> !output_enable_n)
        else $error("drive without enable");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> ready_busy_flag && !data_oe)
        else $error("not idle after reset");
endmodule

// ==== testbench/nvm_programmer_model.sv ====
`timescale 1ns/100ps
module nvm_programmer_model
(
    input  wire logic           clk,
    output nvm_port_pkg::ctrl_s ctrl,
    output logic                load_clock,
    output logic                page_latch_strobe,
    output logic                write_n,
    output logic                output_enable_n
);
    initial
    begin
        ctrl              = '0;
        load_clock        = 1'b0;
        page_latch_strobe = 1'b0;
        write_n           = 1'b1;
        output_enable_n   = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // 5-cycle phases cover the two-flop sync delay
    task automatic load(input logic [1:0] a, s, input logic [7:0] d);
        @(posedge clk);
        ctrl <= '{act: a, sel: s, data: d};
        cyc(5);
        load_clock <= 1'b1;
        cyc(5);
        load_clock <= 1'b0;
        cyc(5);
    endtask

    task automatic latch();
        @(posedge clk);
        ctrl.sel <= 2'h1;
        cyc(5);
        page_latch_strobe <= 1'b1;
        cyc(5);
        page_latch_strobe <= 1'b0;
        cyc(5);
    endtask

    task automatic wr_low(input logic [1:0] s);
        @(posedge clk);
        ctrl.sel <= s;
        cyc(5);
        write_n <= 1'b0;
    endtask

    task automatic wr_high();
        @(posedge clk);
        write_n  <= 1'b1;
        ctrl.sel <= 2'h0;
    endtask

    task automatic set_oe(input logic [1:0] s, input logic v);
        @(posedge clk);
        ctrl.sel        <= s;
        output_enable_n <= v;
        cyc(8);
    endtask
endmodule

// ==== testbench/parallel_nvm_programming_port_test.sv ====
`timescale 1ns/100ps
module parallel_nvm_programming_port_test;
    localparam int         WR_CYC = 20;
    localparam int         CE_CYC = 60;
    localparam logic [7:0] SIG0   = 8'h5a;  // arbitrary
    localparam logic [7:0] SIG1   = 8'h3c;  // arbitrary
    localparam logic [7:0] SIG2   = 8'h96;  // arbitrary
    localparam logic [7:0] CAL    = 8'h47;
    logic                clk = 1'b0;
    logic                rst_n;
    nvm_port_pkg::ctrl_s ctrl;
    logic                lclk, plat, wr_n, oe_n, data_oe, rdy;
    logic [7:0]          data_out, bus, lockv;
    logic [7:0]          eb [8], fuse [3], sig [3], lk [4];
    logic [15:0]         fw [8];
    logic [2:0]          pg;
    int                  error_cnt, n_checks, seed;

    always #12.5 clk = ~clk;
    // released bus reads inverted while oe_n is low
    assign bus = data_oe ? data_out : (oe_n ? ctrl.data : ~ctrl.data);

    nvm_programmer_model u_nvm_programmer_model
    (
        .clk, .ctrl, .load_clock(lclk), .page_latch_strobe(plat), .write_n(wr_n),
        .output_enable_n(oe_n)
    );

    nvm_prog_port #(.WR_CYC(WR_CYC), .CE_CYC(CE_CYC), .SIG0(SIG0), .SIG1(SIG1),
        .SIG2(SIG2), .CAL(CAL)) u_nvm_prog_port
    (
        .clk, .rst_n, .action_select_hi(ctrl.act[1]), .action_select_lo(ctrl.act[0]),
        .byte_select_one(ctrl.sel[0]), .byte_select_two(ctrl.sel[1]), .load_clock(lclk),
        .page_latch_strobe(plat), .write_n(wr_n), .output_enable_n(oe_n), .data_in(bus),
        .data_out, .data_oe, .ready_busy_flag(rdy)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    task automatic check8(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_rng(input string nm, input int lo, hi, g);
        n_checks++;
        if (g < lo || g > hi)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    function automatic logic [7:0] lock_nxt(input logic [7:0] o, d);
        if ((o & nvm_port_pkg::LOCK_MODE) == 8'h00)
            return o & (d | nvm_port_pkg::BOOT_LOCKS);
        return o & d;
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    task automatic cmd(input logic [7:0] c);
        u_nvm_programmer_model.load(nvm_port_pkg::ACT_CMD, 2'h0, c);
    endtask

    task automatic addr(input logic [1:0] s, input logic [7:0] d);
        u_nvm_programmer_model.load(nvm_port_pkg::ACT_ADDR, s, d);
    endtask

    task automatic dat(input logic [1:0] s, input logic [7:0] d);
        u_nvm_programmer_model.load(nvm_port_pkg::ACT_DATA, s, d);
    endtask

    // exp 0: strobe must be ignored
    task automatic commit(input logic [1:0] s, input int exp);
        int n = 0;
        int m = 0;
        u_nvm_programmer_model.wr_low(s);
        while (rdy === 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        u_nvm_programmer_model.wr_high();
        if (exp == 0)
        begin
            check_rng("ignored strobe", 60, 60, n);
            return;
        end
        check_rng("busy start", 0, 40, n);
        while (rdy !== 1'b1 && m < CE_CYC * 2)
        begin
            @(negedge clk);
            m++;
        end
        check_rng("busy time", exp - 2, exp + 8, n + m);
        if (n == 60 || m == CE_CYC * 2)
            end_sim();
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        u_nvm_programmer_model.set_oe(s, 1'b0);
        @(negedge clk);
        check8("data_oe", 8'h01, {7'h0, data_oe});
        check8("read byte", e, data_out);
        u_nvm_programmer_model.set_oe(2'h0, 1'b1);
        @(negedge clk);
        check8("bus released", 8'h00, {7'h0, data_oe});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        seed      = 95312;
        error_cnt = 0;
        n_checks  = 0;
        sig       = '{SIG0, SIG1, SIG2};
        lk        = '{8'hfe, 8'hff, 8'hfc, 8'hc3};
        rst_n     = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check8("ready after reset", 8'h01, {7'h0, rdy});
        // odd page exposes a misrouted top byte
        pg = {2'($random(seed)), 1'b1};
        cmd(nvm_port_pkg::CMD_WR_FLASH);
        for (int w = 0; w < 8; w++)
        begin
            fw[w] = 16'($random(seed));
            addr(2'h0, {2'h0, pg, 3'(w)});
            dat(2'h0, fw[w][7:0]);
            dat(2'h1, fw[w][15:8]);
            u_nvm_programmer_model.load(2'h3, 2'h1, ~fw[w][15:8]);
            u_nvm_programmer_model.latch();
        end
        addr(2'h1, 8'h00);
        addr(2'h2, 8'h00);
        commit(2'h0, WR_CYC);
        cmd(nvm_port_pkg::CMD_NOP);
        commit(2'h0, 0);
        cmd(nvm_port_pkg::CMD_RD_FLASH);
        for (int w = 0; w < 8; w++)
        begin
            addr(2'h0, {2'h0, pg, 3'(w)});
            rd(2'h0, fw[w][7:0]);
            rd(2'h1, fw[w][15:8]);
        end
        cmd(nvm_port_pkg::CMD_WR_EEPROM);
        addr(2'h1, 8'h00);
        for (int w = 0; w < 8; w++)
        begin
            eb[w] = 8'($random(seed));
            addr(2'h0, {2'h0, pg, 3'(w)});
            dat(2'h0, eb[w]);
            u_nvm_programmer_model.latch();
        end
        commit(2'h0, WR_CYC);
        cmd(nvm_port_pkg::CMD_RD_EEPROM);
        for (int w = 0; w < 8; w++)
        begin
            addr(2'h0, {2'h0, pg, 3'(w)});
            rd(2'h0, eb[w]);
        end
        cmd(nvm_port_pkg::CMD_WR_FUSE);
        for (int t = 0; t < 3; t++)
        begin
            fuse[t] = 8'($random(seed));
            dat(2'h0, fuse[t]);
            commit(2'(t), WR_CYC);
        end
        u_nvm_programmer_model.set_oe(2'h0, 1'b0);
        @(negedge clk);
        check8("idle drive", 8'h00, {7'h0, data_oe});
        u_nvm_programmer_model.set_oe(2'h0, 1'b1);
        cmd(nvm_port_pkg::CMD_RD_FUSE);
        rd(2'h0, fuse[0]);
        rd(2'h3, fuse[1]);
        rd(2'h2, fuse[2]);
        lockv = 8'hff;
        for (int i = 0; i < 4; i++)
        begin
            cmd(nvm_port_pkg::CMD_WR_LOCK);
            dat(2'h0, lk[i]);
            commit(2'h0, WR_CYC);
            lockv = lock_nxt(lockv, lk[i]);
            cmd(nvm_port_pkg::CMD_RD_FUSE);
            rd(2'h1, lockv);
        end
        cmd(nvm_port_pkg::CMD_CHIP_ERASE);
        commit(2'h0, CE_CYC);
        cmd(nvm_port_pkg::CMD_RD_FUSE);
        rd(2'h1, 8'hff);
        cmd(nvm_port_pkg::CMD_RD_SIG);
        for (int i = 0; i < 3; i++)
        begin
            addr(2'h0, 8'(i));
            rd(2'h0, sig[i]);
        end
        addr(2'h0, 8'h00);
        rd(2'h1, CAL);
        end_sim();
    end
endmodule

bind nvm_prog_port nvm_prog_port_sva #(.WR_CYC(WR_CYC), .CE_CYC(CE_CYC)) u_nvm_prog_port_sva
    (.clk, .rst_n, .write_n, .output_enable_n, .data_oe, .ready_busy_flag);
